// [prac_pkg.sv]
// Purpose: shared constants for the program memory access block
// Assumes: 16-bit program words, 12-bit program counter
// Notes: SFR space is byte wide with nine address bits
package prac_pkg;
  localparam int unsigned PRAC_WORD_W = 16;
  localparam int unsigned PRAC_PC_W = 12;
  localparam int unsigned PRAC_ROM_WORDS = 4096;
  localparam int unsigned PRAC_ROM_WORDS_SMALL = 2048;
  localparam int unsigned PRAC_CFG_WORDS = 32;
  localparam int unsigned PRAC_CFG_AW = 5;
  localparam int unsigned PRAC_SFR_AW = 9;
  localparam logic [8:0] PRAC_RDLY_ADDR = 9'h113;
  localparam logic [7:0] PRAC_RDLY_RESET = 8'h00;
  localparam int unsigned PRAC_RDLY_LSB = 0;
  localparam int unsigned PRAC_RDLY_MSB = 1;
  localparam logic [15:0] PRAC_CFG_RESET = 16'h0200;
  localparam int unsigned PRAC_CFG_PROT_BIT = 15;
  localparam logic [4:0] PRAC_CFG_IDX = 5'h00;
  localparam logic [11:0] PRAC_RESET_VEC = 12'h000;
  localparam logic [11:0] PRAC_INT_VEC = 12'h004;
  localparam logic [15:0] PRAC_ERASED = 16'hffff;
  localparam logic [15:0] PRAC_READ_BLOCKED = 16'h0000;
  // Strobe delays in ns, and their cycle counts at 250 MHz rounded up
  localparam int unsigned PRAC_CLK_PERIOD_NS = 4;
  localparam int unsigned PRAC_DLY0_NS = 20;
  localparam int unsigned PRAC_DLY1_NS = 16;
  localparam int unsigned PRAC_DLY2_NS = 12;
  localparam int unsigned PRAC_DLY3_NS = 8;
  localparam logic [3:0] PRAC_DLY0_CYC = 4'((PRAC_DLY0_NS + PRAC_CLK_PERIOD_NS - 1) / PRAC_CLK_PERIOD_NS);
  localparam logic [3:0] PRAC_DLY1_CYC = 4'((PRAC_DLY1_NS + PRAC_CLK_PERIOD_NS - 1) / PRAC_CLK_PERIOD_NS);
  localparam logic [3:0] PRAC_DLY2_CYC = 4'((PRAC_DLY2_NS + PRAC_CLK_PERIOD_NS - 1) / PRAC_CLK_PERIOD_NS);
  localparam logic [3:0] PRAC_DLY3_CYC = 4'((PRAC_DLY3_NS + PRAC_CLK_PERIOD_NS - 1) / PRAC_CLK_PERIOD_NS);
  localparam int unsigned PRAC_STACK_DEPTH = 8;
endpackage : prac_pkg

// [prac_rd_if.sv]
// Purpose: read request carrier between access top and read timer
// Assumes: single clock domain
// Notes: one request in flight at a time
interface prac_rd_if;
  logic start;
  logic [1:0] sel;
  logic done;
  logic busy;
  modport ctrl (output start, output sel, input done, input busy);
  modport tmr (input start, input sel, output done, output busy);
endinterface : prac_rd_if

// [prac_rd_timer.sv]
// Purpose: stretch each CPU fetch and table read by the selected strobe delay
// Assumes: start only while not busy
// Notes: done is a one-cycle pulse after the delay count
module prac_rd_timer (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  prac_rd_if.tmr rd
);
  import prac_pkg::*;
  logic [3:0] cnt_q;
  logic busy_q;
  logic done_q;
  logic [3:0] len;

  // --------------------------------------------------------------
  // Delay selection
  // --------------------------------------------------------------
  // Fixed lookup keeps the strobe timing independent of the caller
  always_comb begin
    case (rd.sel)
      2'b00: len = PRAC_DLY0_CYC;
      2'b01: len = PRAC_DLY1_CYC;
      2'b10: len = PRAC_DLY2_CYC;
      default: len = PRAC_DLY3_CYC;
    endcase
  end

  // Down counter for the read strobe
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cnt_q <= 4'h0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (rd.start && !busy_q) begin
        cnt_q <= len - 4'h1;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        if (cnt_q == 4'h0) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          cnt_q <= cnt_q - 4'h1;
        end
      end
    end
  end

  assign rd.busy = busy_q;
  assign rd.done = done_q;
endmodule // prac_rd_timer

// [prac_access.sv]
// Purpose: program memory, configuration area, protection and fetch vectors
// Assumes: programmer port and CPU ports synchronous to clk_sys_i
// Notes: config word keeps its contents across resets
// Notes on behaviour
// - 16-bit program memory plus 32-word config area
// - Protect bit set refuses external user reads
// - Programmer cannot read protected user code
// - Config word always readable by programmer
// - Protect clears only after user area erase
// - Protect set blocks user code writes
// - Config written only through programmer path
// - Config word fixes startup operating conditions
// - Two-bit delay field selects 20/16/12/8 ns
// - Reset loads program counter with 000h
// - Reset returns registers to defaults
// - Interrupt pushes PC, jumps to 004h
module prac_access #(
  parameter int unsigned ROM_WORDS = prac_pkg::PRAC_ROM_WORDS
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  // CPU special function register port
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [prac_pkg::PRAC_SFR_AW-1:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  // CPU fetch and table read control
  input wire logic fetch_req_i,
  input wire logic tbl_req_i,
  input wire logic [prac_pkg::PRAC_PC_W-1:0] tbl_addr_i,
  input wire logic jump_i,
  input wire logic [prac_pkg::PRAC_PC_W-1:0] jump_addr_i,
  input wire logic irq_take_i,
  input wire logic ret_i,
  output logic [prac_pkg::PRAC_PC_W-1:0] pc_o,
  output logic [prac_pkg::PRAC_WORD_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic rd_busy_o,
  // External programmer port
  input wire logic prg_rd_i,
  input wire logic prg_wr_i,
  input wire logic prg_erase_i,
  input wire logic prg_cfg_i,
  input wire logic [prac_pkg::PRAC_PC_W-1:0] prg_addr_i,
  input wire logic [prac_pkg::PRAC_WORD_W-1:0] prg_wdata_i,
  output logic [prac_pkg::PRAC_WORD_W-1:0] prg_rdata_o,
  output logic prg_rvalid_o,
  output logic prg_denied_o,
  // Startup options taken from the configuration word
  output logic [prac_pkg::PRAC_WORD_W-1:0] cfg_word_o,
  output logic protect_o
);
  import prac_pkg::*;
  localparam int unsigned AW = $clog2(ROM_WORDS);

  typedef enum logic [1:0] {PRAC_IDLE, PRAC_FETCH, PRAC_TABLE} prac_state_e;

  logic [PRAC_WORD_W-1:0] rom_mem [ROM_WORDS];
  // Power-on contents; nonvolatile, so no reset touches it
  logic [PRAC_WORD_W-1:0] cfg_mem [PRAC_CFG_WORDS] = '{PRAC_CFG_IDX: PRAC_CFG_RESET, default: PRAC_ERASED};
  logic [7:0] rdly_q;
  logic [PRAC_PC_W-1:0] pc_q;
  logic [PRAC_PC_W-1:0] stack_q [PRAC_STACK_DEPTH];
  logic [2:0] sp_q;
  prac_state_e state_q;
  logic [AW-1:0] raddr_q;
  logic [PRAC_WORD_W-1:0] rd_data_q;
  logic rd_valid_q;
  logic [PRAC_WORD_W-1:0] prg_rdata_q;
  logic prg_rvalid_q;
  logic prg_denied_q;
  logic [PRAC_WORD_W-1:0] cfg_word_q;
  logic [7:0] sfr_rdata_q;
  logic user_erased_q;
  logic protect;

  prac_rd_if rd();

  prac_rd_timer u_rd_timer (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .rd(rd)
  );

  assign protect = cfg_mem[PRAC_CFG_IDX][PRAC_CFG_PROT_BIT];

  // --------------------------------------------------------------
  // Read strobe delay register
  // --------------------------------------------------------------
  // Only the two delay bits are stored; upper bits read as zero
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rdly_q <= PRAC_RDLY_RESET;
    end else if (sfr_wr_i && sfr_addr_i == PRAC_RDLY_ADDR) begin
      rdly_q <= {6'h00, sfr_wdata_i[PRAC_RDLY_MSB:PRAC_RDLY_LSB]};
    end
  end

  // Register read-back; unmapped addresses give zero
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      sfr_rdata_q <= 8'h00;
    end else if (sfr_rd_i && sfr_addr_i == PRAC_RDLY_ADDR) begin
      sfr_rdata_q <= rdly_q;
    end else begin
      sfr_rdata_q <= 8'h00;
    end
  end

  // --------------------------------------------------------------
  // Program counter and return stack
  // --------------------------------------------------------------
  // Stack wraps at eight levels, like the core's hardware stack
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      pc_q <= PRAC_RESET_VEC;
      sp_q <= 3'h0;
    end else if (irq_take_i) begin
      stack_q[sp_q] <= pc_q;
      sp_q <= sp_q + 3'h1;
      pc_q <= PRAC_INT_VEC;
    end else if (ret_i) begin
      pc_q <= stack_q[sp_q - 3'h1];
      sp_q <= sp_q - 3'h1;
    end else if (jump_i) begin
      pc_q <= jump_addr_i;
    end else if (rd.done && state_q == PRAC_FETCH) begin
      pc_q <= pc_q + 12'h001;
    end
  end

  // --------------------------------------------------------------
  // Delayed read sequencer for fetches and table reads
  // --------------------------------------------------------------
  // Delay field sampled at each start so a new value hits the next read
  assign rd.sel = rdly_q[PRAC_RDLY_MSB:PRAC_RDLY_LSB];
  assign rd.start = (state_q == PRAC_IDLE) && !rd.busy && (fetch_req_i || tbl_req_i);

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state_q <= PRAC_IDLE;
      raddr_q <= '0;
      rd_data_q <= '0;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= 1'b0;
      case (state_q)
        PRAC_IDLE: begin
          if (tbl_req_i && !rd.busy) begin
            raddr_q <= tbl_addr_i[AW-1:0];
            state_q <= PRAC_TABLE;
          end else if (fetch_req_i && !rd.busy) begin
            raddr_q <= pc_q[AW-1:0];
            state_q <= PRAC_FETCH;
          end
        end
        PRAC_FETCH, PRAC_TABLE: begin
          if (rd.done) begin
            rd_data_q <= rom_mem[raddr_q];
            rd_valid_q <= 1'b1;
            state_q <= PRAC_IDLE;
          end
        end
        default: state_q <= PRAC_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // Programmer writes, erase and protection
  // --------------------------------------------------------------
  // Erase wipes user code first; only then may protect be cleared
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      user_erased_q <= 1'b0;
    end else if (prg_erase_i && !prg_cfg_i) begin
      user_erased_q <= 1'b1;
    end else if (prg_wr_i && !prg_cfg_i && !protect) begin
      user_erased_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (prg_erase_i && !prg_cfg_i) begin
      for (int i = 0; i < ROM_WORDS; i++) begin
        rom_mem[i] <= PRAC_ERASED;
      end
    end else if (prg_wr_i && !prg_cfg_i && !protect) begin
      rom_mem[prg_addr_i[AW-1:0]] <= prg_wdata_i;
    end
  end

  // No CPU path reaches this memory; the programmer alone writes it
  always_ff @(posedge clk_sys_i) begin
    if (prg_wr_i && prg_cfg_i) begin
      if (prg_addr_i[PRAC_CFG_AW-1:0] == PRAC_CFG_IDX && protect &&
          !prg_wdata_i[PRAC_CFG_PROT_BIT] && !user_erased_q) begin
        cfg_mem[PRAC_CFG_IDX] <= {1'b1, prg_wdata_i[PRAC_CFG_PROT_BIT-1:0]};
      end else begin
        cfg_mem[prg_addr_i[PRAC_CFG_AW-1:0]] <= prg_wdata_i;
      end
    end
  end

  // --------------------------------------------------------------
  // Programmer read-back
  // --------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      prg_rdata_q <= '0;
      prg_rvalid_q <= 1'b0;
      prg_denied_q <= 1'b0;
    end else begin
      prg_rvalid_q <= prg_rd_i;
      prg_denied_q <= 1'b0;
      if (prg_rd_i && prg_cfg_i) begin
        prg_rdata_q <= cfg_mem[prg_addr_i[PRAC_CFG_AW-1:0]];
      end else if (prg_rd_i && protect) begin
        prg_rdata_q <= PRAC_READ_BLOCKED;
        prg_denied_q <= 1'b1;
      end else if (prg_rd_i) begin
        prg_rdata_q <= rom_mem[prg_addr_i[AW-1:0]];
      end
    end
  end

  // Startup options latched at every reset
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cfg_word_q <= cfg_mem[PRAC_CFG_IDX];
    end
  end

  assign sfr_rdata_o = sfr_rdata_q;
  assign pc_o = pc_q;
  assign rd_data_o = rd_data_q;
  assign rd_valid_o = rd_valid_q;
  assign rd_busy_o = rd.busy;
  assign prg_rdata_o = prg_rdata_q;
  assign prg_rvalid_o = prg_rvalid_q;
  assign prg_denied_o = prg_denied_q;
  assign cfg_word_o = cfg_word_q;
  assign protect_o = cfg_word_q[PRAC_CFG_PROT_BIT];
endmodule // prac_access

// [prac_access_asserts.sv]
// Purpose: port-level checks for the program memory access block
// Assumes: one clock, synchronous active-low reset
// Notes: delay field mirrored from SFR writes to predict read latency
module prac_access_asserts (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  input wire logic [8:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic irq_take_i,
  input wire logic [11:0] pc_o,
  input wire logic rd_valid_o,
  input wire logic rd_busy_o,
  input wire logic prg_rd_i,
  input wire logic prg_cfg_i,
  input wire logic [15:0] prg_rdata_o,
  input wire logic prg_rvalid_o,
  input wire logic prg_denied_o,
  input wire logic protect_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] dly_q;
  logic [3:0] age_q;
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  // Delay field mirror; a write during a read would skew the latency check
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) dly_q <= 2'h0;
    else if (sfr_wr_i && sfr_addr_i == 9'h113) dly_q <= sfr_wdata_i[1:0];
  end
  // Cycles since the read timer turned busy, saturating
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) age_q <= 4'h0;
    else if ($rose(rd_busy_o)) age_q <= 4'h1;
    else if (age_q != 4'hf) age_q <= age_q + 4'h1;
  end
  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  sfr_readback_a: assert property (sfr_rd_i && sfr_addr_i == 9'h113 |=> sfr_rdata_o == {6'h00, $past(dly_q)})
    else $error("delay readback wrong");
  sfr_unmapped_a: assert property (sfr_rd_i && sfr_addr_i != 9'h113 |=> sfr_rdata_o == 8'h00)
    else $error("unmapped SFR read not zero");
  prg_answer_a: assert property (prg_rd_i |=> prg_rvalid_o)
    else $error("programmer read unanswered");
  prg_locked_a: assert property (prg_rd_i && !prg_cfg_i && protect_o |=> prg_denied_o && prg_rdata_o == 16'h0000)
    else $error("protected user read leaked");
  cfg_open_a: assert property (prg_rd_i && prg_cfg_i |=> !prg_denied_o)
    else $error("config read refused");
  irq_vector_a: assert property (irq_take_i |=> pc_o == 12'h004)
    else $error("interrupt vector wrong");
  reset_pc_a: assert property ($rose(rstn_i) |-> pc_o == 12'h000)
    else $error("reset vector wrong");
  // Busy rises on the taking edge; valid follows the done pulse by one edge
  read_delay_a: assert property (rd_valid_o |-> age_q == 4'h6 - {2'h0, dly_q})
    else $error("read latency wrong");
endmodule // prac_access_asserts

// [prac_cpu_model.sv]
// Purpose: CPU-side stand-in for SFR access, fetch, table read and interrupt
// Assumes: requests launched 1 ns after the rising edge
// Notes: port names match the block so the bench can wire by name
module prac_cpu_model (
  input wire logic clk_sys_i,
  input wire logic rd_valid_o,
  input wire logic [7:0] sfr_rdata_o,
  output logic sfr_wr_i,
  output logic sfr_rd_i,
  output logic [8:0] sfr_addr_i,
  output logic [7:0] sfr_wdata_i,
  output logic fetch_req_i,
  output logic tbl_req_i,
  output logic [11:0] tbl_addr_i,
  output logic jump_i,
  output logic [11:0] jump_addr_i,
  output logic irq_take_i,
  output logic ret_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle levels
  initial begin
    {sfr_wr_i, sfr_rd_i, fetch_req_i, tbl_req_i, jump_i, irq_take_i, ret_i, sfr_addr_i, sfr_wdata_i} = '0;
    {tbl_addr_i, jump_addr_i} = '0;
  end
  // One-cycle SFR access; delay only changed with no read in flight
  task automatic sfr(input logic wr, input logic [8:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys_i) #1;
    sfr_wr_i = wr;
    sfr_rd_i = !wr;
    sfr_addr_i = a;
    sfr_wdata_i = d;
    @(posedge clk_sys_i) #1;
    sfr_wr_i = 1'b0;
    sfr_rd_i = 1'b0;
    q = sfr_rdata_o;
  endtask
  // Request held until the valid pulse; n counts edges from the taking one
  task automatic rd(input logic tbl, input logic [11:0] a, output int n);
    @(posedge clk_sys_i) #1;
    tbl_req_i = tbl;
    fetch_req_i = !tbl;
    tbl_addr_i = a;
    n = 0;
    do begin
      @(posedge clk_sys_i) #1;
      n++;
    end while (!rd_valid_o && n < 40);
    tbl_req_i = 1'b0;
    fetch_req_i = 1'b0;
  endtask
  // Interrupt entry or return, one-cycle pulse
  task automatic pulse(input logic irq);
    @(posedge clk_sys_i) #1;
    irq_take_i = irq;
    ret_i = !irq;
    @(posedge clk_sys_i) #1;
    irq_take_i = 1'b0;
    ret_i = 1'b0;
  endtask
  // Jump with a one-cycle load strobe
  task automatic jump(input logic [11:0] a);
    @(posedge clk_sys_i) #1;
    jump_i = 1'b1;
    jump_addr_i = a;
    @(posedge clk_sys_i) #1;
    jump_i = 1'b0;
  endtask
endmodule // prac_cpu_model

// [prac_access_tb.sv]
// Purpose: self-checking bench for the program memory access block
// Assumes: 250 MHz clock, 4K-word memory, config word 0200 after power-up
// Notes: protection flips are checked across a reset, as the copy is reset-time
module prac_access_tb;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic [1:0] dly; logic [3:0] lat;} prac_row_s;
  localparam logic [3:0] RD = 4'h8, WR = 4'h4, ER = 4'h2, CF = 4'h1;
  logic clk_sys_i, rstn_i, sfr_wr_i, sfr_rd_i, fetch_req_i, tbl_req_i, jump_i, irq_take_i, ret_i;
  logic rd_valid_o, rd_busy_o, prg_rd_i, prg_wr_i, prg_erase_i, prg_cfg_i, prg_rvalid_o, prg_denied_o, protect_o;
  logic [8:0] sfr_addr_i;
  logic [7:0] sfr_wdata_i, sfr_rdata_o, b;
  logic [11:0] tbl_addr_i, jump_addr_i, pc_o, prg_addr_i;
  logic [15:0] rd_data_o, prg_wdata_i, prg_rdata_o, cfg_word_o, q;
  int n_mismatch = 0;
  int tests_run = 0;
  int n;
  // Edges counted from the taking edge to the valid pulse: delay cycles plus two
  prac_row_s rows [4] = '{'{2'b00, 4'h7}, '{2'b01, 4'h6}, '{2'b10, 4'h5}, '{2'b11, 4'h4}};
  prac_access i_prac_access (.*);
  prac_cpu_model i_prac_cpu_model (.*);
  // ------------------------------------------------------------
  // Clock, helpers
  // ------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic reset_dut(input int cyc);
    @(posedge clk_sys_i) #1;
    rstn_i = 1'b0;
    repeat (cyc) @(posedge clk_sys_i);
    #1 rstn_i = 1'b1;
  endtask
  // Programmer strobe for one cycle; answer taken the cycle after
  task automatic prg(input logic [3:0] op, input logic [11:0] a, input logic [15:0] d, output logic [15:0] r);
    @(posedge clk_sys_i) #1;
    {prg_rd_i, prg_wr_i, prg_erase_i, prg_cfg_i} = op;
    prg_addr_i = a;
    prg_wdata_i = d;
    @(posedge clk_sys_i) #1;
    {prg_rd_i, prg_wr_i, prg_erase_i, prg_cfg_i} = 4'h0;
    r = prg_rdata_o;
  endtask
  task automatic wrap_up;
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Whole run is about 110 cycles; 5000 means a hang
  initial begin
    #20000;
    n_mismatch++;
    wrap_up();
  end
  // Main sequence: reset, delay table, then protection walk
  initial begin
    rstn_i = 1'b0;
    {prg_rd_i, prg_wr_i, prg_erase_i, prg_cfg_i, prg_addr_i, prg_wdata_i} = '0;
    reset_dut(8);
    chk(16'(pc_o), 16'h0000);
    chk(cfg_word_o, 16'h0200);
    i_prac_cpu_model.sfr(1'b0, 9'h113, 8'h00, b);
    chk(16'(b), 16'h0000);
    i_prac_cpu_model.sfr(1'b1, 9'h112, 8'hff, b);
    i_prac_cpu_model.sfr(1'b0, 9'h112, 8'h00, b);
    chk(16'(b), 16'h0000);
    i_prac_cpu_model.pulse(1'b1);
    chk(16'(pc_o), 16'h0004);
    i_prac_cpu_model.pulse(1'b0);
    chk(16'(pc_o), 16'h0000);
    // Slowest to fastest; ends on the low-voltage setting
    foreach (rows[i]) begin
      i_prac_cpu_model.sfr(1'b1, 9'h113, {6'h3f, rows[i].dly}, b);
      i_prac_cpu_model.sfr(1'b0, 9'h113, 8'h00, b);
      chk(16'(b), 16'(rows[i].dly));
      i_prac_cpu_model.rd(1'b0, 12'h000, n);
      chk(16'(n), 16'(rows[i].lat));
      chk(16'(pc_o), 16'(i + 1));
    end
    // Return must restore the pushed address, not a vector
    i_prac_cpu_model.jump(12'h0a5);
    chk(16'(pc_o), 16'h00a5);
    i_prac_cpu_model.pulse(1'b1);
    chk(16'(pc_o), 16'h0004);
    i_prac_cpu_model.pulse(1'b0);
    chk(16'(pc_o), 16'h00a5);
    prg(WR, 12'hfff, 16'h1234, q);
    i_prac_cpu_model.rd(1'b1, 12'hfff, n);
    chk(rd_data_o, 16'h1234);
    prg(RD, 12'hfff, 16'h0000, q);
    chk(q, 16'h1234);
    prg(WR | CF, 12'h000, 16'h8200, q);
    chk(cfg_word_o, 16'h0200);
    reset_dut(2);
    chk(cfg_word_o, 16'h8200);
    chk(16'(protect_o), 16'h0001);
    prg(RD, 12'hfff, 16'h0000, q);
    chk(q, 16'h0000);
    prg(RD | CF, 12'h000, 16'h0000, q);
    chk(q, 16'h8200);
    prg(WR, 12'hfff, 16'h5678, q);
    i_prac_cpu_model.rd(1'b1, 12'hfff, n);
    chk(rd_data_o, 16'h1234);
    prg(WR | CF, 12'h000, 16'h0200, q);
    prg(RD | CF, 12'h000, 16'h0000, q);
    chk(q, 16'h8200);
    prg(ER, 12'h000, 16'h0000, q);
    i_prac_cpu_model.rd(1'b1, 12'hfff, n);
    chk(rd_data_o, 16'hffff);
    prg(WR | CF, 12'h000, 16'h0200, q);
    prg(RD | CF, 12'h000, 16'h0000, q);
    chk(q, 16'h0200);
    reset_dut(2);
    chk(16'(protect_o), 16'h0000);
    chk(16'(pc_o), 16'h0000);
    i_prac_cpu_model.sfr(1'b0, 9'h113, 8'h00, b);
    chk(16'(b), 16'h0000);
    wrap_up();
  end
endmodule // prac_access_tb
bind prac_access prac_access_asserts i_prac_access_asserts (.*);
